// *** rtl/smbus_mem_pkg.sv ***
// Purpose: Shared constants and state types for the two-wire memory port.
// Assumes: 50 MHz system clock on both ends.
// Notes: Slave address default is arbitrary; the top module overrides it.
package smbus_mem_pkg;
  localparam int unsigned SYS_PERIOD_NS = 20;
  localparam int unsigned SCL_PERIOD_NS = 10000;
  // Host quarter bit period, rounded down to whole cycles
  localparam int unsigned SCL_QUARTER_CYC = SCL_PERIOD_NS / (4 * SYS_PERIOD_NS);
  localparam int unsigned FILT_LEN = 3;
  localparam logic [2:0] IDLE_TICKS = 3'h4;
  localparam logic [6:0] SLAVE_ADDR_DFLT = 7'h5A;
  localparam int unsigned ADDR_W = 10;
  localparam int unsigned BANK_W = 2;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  // Pointer byte 0 layout: bank in [7:6], location bits 9:8 in [1:0]
  localparam int unsigned PTR_BANK_LSB = 6;
  localparam logic [1:0] IDX_PTR_HI = 2'h0;
  localparam logic [1:0] IDX_PTR_LO = 2'h1;
  localparam logic [1:0] IDX_DATA = 2'h2;
  localparam logic [1:0] BANK_EEPROM = 2'h0;
  localparam logic [1:0] BANK_RAM_REG = 2'h1;
  localparam logic [1:0] BANK_TEST = 2'h2;
  localparam logic [1:0] BANK_RSVD = 2'h3;
  localparam logic [7:0] RSVD_RDATA = 8'hFF;

  typedef enum logic [2:0] {
    D_IDLE = 3'h0,
    D_RX = 3'h1,
    D_RACK = 3'h3,
    D_TX = 3'h2,
    D_TACK = 3'h6
  } dev_state_t;

  typedef enum logic [1:0] {
    H_IDLE = 2'h0,
    H_START = 2'h1,
    H_BIT = 2'h3,
    H_STOP = 2'h2
  } host_state_t;
endpackage

// *** rtl/smbus_if.sv ***
// Purpose: Open-drain two-wire link joining the host end and the device end.
// Assumes: A pull-up on each line; an enable low pulls the line to the _o level.
// Notes: The wired-AND level is resolved here, not in the ends.
`timescale 1ns/1ns
interface smbus_if;
  logic scl_h_o;
  logic scl_h_oe_n;
  logic sda_h_o;
  logic sda_h_oe_n;
  logic scl_d_o;
  logic scl_d_oe_n;
  logic sda_d_o;
  logic sda_d_oe_n;
  logic scl;
  logic sda;

  // Wired-AND with pull-up
  assign scl = (scl_h_oe_n | scl_h_o) & (scl_d_oe_n | scl_d_o);
  assign sda = (sda_h_oe_n | sda_h_o) & (sda_d_oe_n | sda_d_o);

  modport host (input scl, input sda, output scl_h_o, output scl_h_oe_n,
                output sda_h_o, output sda_h_oe_n);
  modport dev (input scl, input sda, output scl_d_o, output scl_d_oe_n,
               output sda_d_o, output sda_d_oe_n);
endinterface // smbus_if

// *** rtl/smbus_slave_mem.sv ***
// Purpose: Slave end of the two-wire link giving access to a banked memory space.
// Assumes: Memory answers mem_rdata the cycle after mem_rd; ee_busy is same-domain.
// Notes: Byte 0 after a write address sets bank and location 9:8, byte 1 sets 7:0.
`timescale 1ns/1ns
module smbus_slave_mem #(
  parameter logic [6:0] SLAVE_ADDR = smbus_mem_pkg::SLAVE_ADDR_DFLT
) (
  input wire logic sys_clk,
  input wire logic rstn,
  smbus_if.dev bus,
  output logic mem_wr,
  output logic mem_rd,
  output logic [smbus_mem_pkg::BANK_W-1:0] mem_bank,
  output logic [smbus_mem_pkg::ADDR_W-1:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic ee_sel,
  output logic ram_sel,
  output logic test_sel,
  input wire logic [7:0] mem_rdata,
  input wire logic ee_busy,
  output logic bus_active
);
  localparam int unsigned FL = smbus_mem_pkg::FILT_LEN;

  smbus_mem_pkg::dev_state_t state_q;
  logic [1:0] scl_sync_q, sda_sync_q;
  logic [FL-1:0] scl_hist_q, sda_hist_q;
  logic scl_f_q, sda_f_q, scl_p_q, sda_p_q;
  logic scl_rise, scl_fall, start_cond, stop_cond;
  logic [3:0] bit_q;
  logic [7:0] shreg_q;
  logic addr_phase_q, rw_q, ack_q, sda_oe_n_q, rd_pend_q, rd_take_q, mem_wr_q, mem_rd_q;
  logic [1:0] idx_q;
  logic [smbus_mem_pkg::BANK_W-1:0] ptr_bank_q, mem_bank_q;
  logic [smbus_mem_pkg::ADDR_W-1:0] ptr_addr_q, mem_addr_q;
  logic [7:0] mem_wdata_q;
  logic [2:0] sel_q;
  logic active_q;
  logic byte_done, addr_hit, ptr_is_ee, ack_ok, wr_fire, rd_fire;

  // Decode bank to {test, ram/regs, eeprom} selects; reserved selects nothing
  function automatic logic [2:0] bank_dec(input logic [1:0] bank);
    logic [2:0] sel;
    sel = 3'h0;
    unique case (bank)
      smbus_mem_pkg::BANK_EEPROM: sel = 3'h1;
      smbus_mem_pkg::BANK_RAM_REG: sel = 3'h2;
      smbus_mem_pkg::BANK_TEST: sel = 3'h4;
      smbus_mem_pkg::BANK_RSVD: sel = 3'h0;
    endcase
    return sel;
  endfunction

  // A filtered line moves only when the whole history agrees
  function automatic logic settle(input logic [FL-1:0] hist, input logic cur);
    logic res;
    res = cur;
    if (&hist) res = 1'b1;
    if (~|hist) res = 1'b0;
    return res;
  endfunction

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
    end else begin
      scl_sync_q <= {scl_sync_q[0], bus.scl};
      sda_sync_q <= {sda_sync_q[0], bus.sda};
    end
  end

  // Glitch filter; a pulse shorter than FL cycles is dropped
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      scl_hist_q <= '1;
      sda_hist_q <= '1;
      scl_f_q <= 1'b1;
      sda_f_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_hist_q <= {scl_hist_q[FL-2:0], scl_sync_q[1]};
      sda_hist_q <= {sda_hist_q[FL-2:0], sda_sync_q[1]};
      scl_f_q <= settle(scl_hist_q, scl_f_q);
      sda_f_q <= settle(sda_hist_q, sda_f_q);
      scl_p_q <= scl_f_q;
      sda_p_q <= sda_f_q;
    end
  end

  // Data edges with clock high are conditions, not bits
  assign scl_rise = scl_f_q & ~scl_p_q;
  assign scl_fall = ~scl_f_q & scl_p_q;
  assign start_cond = scl_f_q & scl_p_q & sda_p_q & ~sda_f_q;
  assign stop_cond = scl_f_q & scl_p_q & ~sda_p_q & sda_f_q;

  // Address and direction compared in hardware
  assign byte_done = (state_q == smbus_mem_pkg::D_RX) && scl_fall &&
                     (bit_q == smbus_mem_pkg::BITS_PER_BYTE);
  assign addr_hit = (shreg_q[7:1] == SLAVE_ADDR);
  assign ptr_is_ee = (ptr_bank_q == smbus_mem_pkg::BANK_EEPROM);
  // EEPROM reads and data writes refused while a write is running
  assign ack_ok = addr_phase_q ? (addr_hit && !(shreg_q[0] && ptr_is_ee && ee_busy))
                               : !((idx_q == smbus_mem_pkg::IDX_DATA) && ptr_is_ee && ee_busy);
  // Bus traffic only ever reads or writes a location
  assign wr_fire = byte_done && !addr_phase_q && ack_ok &&
                   (idx_q == smbus_mem_pkg::IDX_DATA);
  assign rd_fire = (byte_done && addr_phase_q && ack_ok && shreg_q[0]) ||
                   ((state_q == smbus_mem_pkg::D_TACK) && scl_rise && !sda_f_q);

  // Bit engine; the slave only ever touches SDA
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= smbus_mem_pkg::D_IDLE;
      bit_q <= 4'h0;
      shreg_q <= 8'h00;
      addr_phase_q <= 1'b0;
      rw_q <= 1'b0;
      ack_q <= 1'b0;
      sda_oe_n_q <= 1'b1;
    end else begin
      if (start_cond) begin
        // Repeated start restarts address phase at once
        state_q <= smbus_mem_pkg::D_RX;
        bit_q <= 4'h0;
        addr_phase_q <= 1'b1;
        sda_oe_n_q <= 1'b1;
      end else if (stop_cond) begin
        state_q <= smbus_mem_pkg::D_IDLE;
        sda_oe_n_q <= 1'b1;
      end else begin
        unique case (state_q)
          smbus_mem_pkg::D_IDLE: sda_oe_n_q <= 1'b1;
          smbus_mem_pkg::D_RX: begin
            // One bit per clock pulse, sampled on the rise
            if (scl_rise && bit_q < smbus_mem_pkg::BITS_PER_BYTE) begin
              shreg_q <= {shreg_q[6:0], sda_f_q};
              bit_q <= bit_q + 4'h1;
            end
            if (byte_done) begin
              if (ack_ok) begin
                // Pull low from the fall before the ninth pulse
                sda_oe_n_q <= 1'b0;
                state_q <= smbus_mem_pkg::D_RACK;
                if (addr_phase_q) rw_q <= shreg_q[0];
              end else begin
                // Unaddressed or refused: stay off the bus until next start
                state_q <= smbus_mem_pkg::D_IDLE;
              end
            end
          end
          smbus_mem_pkg::D_RACK: begin
            if (scl_fall) begin
              addr_phase_q <= 1'b0;
              if (rw_q) begin
                state_q <= smbus_mem_pkg::D_TX;
                sda_oe_n_q <= shreg_q[7];
                shreg_q <= {shreg_q[6:0], 1'b1};
                bit_q <= 4'h1;
              end else begin
                // Keep taking bytes until the master ends
                state_q <= smbus_mem_pkg::D_RX;
                sda_oe_n_q <= 1'b1;
                bit_q <= 4'h0;
              end
            end
          end
          smbus_mem_pkg::D_TX: begin
            // Drive the next bit only after the clock falls
            if (scl_fall) begin
              if (bit_q == smbus_mem_pkg::BITS_PER_BYTE) begin
                state_q <= smbus_mem_pkg::D_TACK;
                sda_oe_n_q <= 1'b1;
              end else begin
                sda_oe_n_q <= shreg_q[7];
                shreg_q <= {shreg_q[6:0], 1'b1};
                bit_q <= bit_q + 4'h1;
              end
            end
          end
          smbus_mem_pkg::D_TACK: begin
            if (scl_rise) ack_q <= !sda_f_q;
            if (scl_fall) begin
              if (ack_q) begin
                state_q <= smbus_mem_pkg::D_TX;
                sda_oe_n_q <= shreg_q[7];
                shreg_q <= {shreg_q[6:0], 1'b1};
                bit_q <= 4'h1;
              end else begin
                // No acknowledge: leave data high for the stop
                state_q <= smbus_mem_pkg::D_IDLE;
                sda_oe_n_q <= 1'b1;
              end
            end
          end
          default: begin
            state_q <= smbus_mem_pkg::D_IDLE;
            sda_oe_n_q <= 1'b1;
          end
        endcase
      end
      // Registered memory answers the cycle after its strobe, still well before the clock falls
      if (rd_take_q) begin
        shreg_q <= (mem_bank_q == smbus_mem_pkg::BANK_RSVD) ? smbus_mem_pkg::RSVD_RDATA
                                                            : mem_rdata;
      end
    end
  end

  // Pointer: bank plus ten-bit location, auto-incremented per data byte
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ptr_bank_q <= 2'h0;
      ptr_addr_q <= 10'h000;
      idx_q <= 2'h0;
    end else begin
      if (start_cond) begin
        idx_q <= smbus_mem_pkg::IDX_PTR_HI;
      end else if (byte_done && !addr_phase_q && ack_ok) begin
        unique case (idx_q)
          smbus_mem_pkg::IDX_PTR_HI: begin
            ptr_bank_q <= shreg_q[7:smbus_mem_pkg::PTR_BANK_LSB];
            ptr_addr_q <= {shreg_q[1:0], ptr_addr_q[7:0]};
            idx_q <= smbus_mem_pkg::IDX_PTR_LO;
          end
          smbus_mem_pkg::IDX_PTR_LO: begin
            ptr_addr_q <= {ptr_addr_q[9:8], shreg_q};
            idx_q <= smbus_mem_pkg::IDX_DATA;
          end
          default: ptr_addr_q <= ptr_addr_q + 10'h001;
        endcase
      end else if (rd_fire) begin
        ptr_addr_q <= ptr_addr_q + 10'h001;
      end
    end
  end

  // Memory strobes with bank decode; reserved bank is never strobed
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      mem_wr_q <= 1'b0;
      mem_rd_q <= 1'b0;
      {rd_pend_q, rd_take_q} <= 2'h0;
      mem_bank_q <= 2'h0;
      mem_addr_q <= 10'h000;
      mem_wdata_q <= 8'h00;
      sel_q <= 3'h0;
    end else begin
      mem_wr_q <= wr_fire && (ptr_bank_q != smbus_mem_pkg::BANK_RSVD);
      mem_rd_q <= rd_fire && (ptr_bank_q != smbus_mem_pkg::BANK_RSVD);
      {rd_take_q, rd_pend_q} <= {rd_pend_q, rd_fire};
      if (wr_fire || rd_fire) begin
        mem_bank_q <= ptr_bank_q;
        mem_addr_q <= ptr_addr_q;
        sel_q <= bank_dec(ptr_bank_q);
      end
      if (wr_fire) mem_wdata_q <= shreg_q;
    end
  end

  // Bus ownership seen from the slave
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) active_q <= 1'b0;
    else if (start_cond) active_q <= 1'b1;
    else if (stop_cond) active_q <= 1'b0;
  end

  // Clock line never pulled; data pulled low only
  assign bus.scl_d_o = 1'b0;
  assign bus.scl_d_oe_n = 1'b1;
  assign bus.sda_d_o = 1'b0;
  assign bus.sda_d_oe_n = sda_oe_n_q;
  assign mem_wr = mem_wr_q;
  assign mem_rd = mem_rd_q;
  assign mem_bank = mem_bank_q;
  assign mem_addr = mem_addr_q;
  assign mem_wdata = mem_wdata_q;
  assign ee_sel = sel_q[0];
  assign ram_sel = sel_q[1];
  assign test_sel = sel_q[2];
  assign bus_active = active_q;
endmodule // smbus_slave_mem

// *** rtl/smbus_host_master.sv ***
// Purpose: Master end of the two-wire link, one byte per command.
// Assumes: Commands come from logic on sys_clk; a quarter bit is QUARTER_CYC cycles.
// Notes: Between bytes without stop the master holds the clock low.
`timescale 1ns/1ns
module smbus_host_master #(
  parameter int unsigned QUARTER_CYC = smbus_mem_pkg::SCL_QUARTER_CYC
) (
  input wire logic sys_clk,
  input wire logic rstn,
  smbus_if.host bus,
  input wire logic cmd_valid,
  input wire logic cmd_start,
  input wire logic cmd_stop,
  input wire logic cmd_read,
  input wire logic cmd_last,
  input wire logic [7:0] cmd_wdata,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_nack,
  output logic rsp_lost
);
  smbus_mem_pkg::host_state_t state_q;
  logic [1:0] scl_sync_q, sda_sync_q;
  logic [15:0] div_q;
  logic tick;
  logic [2:0] idle_cnt_q;
  logic [1:0] q_q;
  logic [3:0] bit_q;
  logic [7:0] shreg_q;
  logic rd_q, last_q, stop_q, held_q, scl_oe_n_q, sda_oe_n_q, ready_q;
  logic rsp_valid_q, rsp_nack_q, rsp_lost_q;
  logic [7:0] rsp_data_q;

  // Line synchronisers
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
    end else begin
      scl_sync_q <= {scl_sync_q[0], bus.scl};
      sda_sync_q <= {sda_sync_q[0], bus.sda};
    end
  end

  // Quarter-bit enable from a free-running divider
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) div_q <= 16'h0000;
    else if (tick) div_q <= 16'h0000;
    else div_q <= div_q + 16'h0001;
  end
  assign tick = (div_q == 16'(QUARTER_CYC - 1));

  // Bus counts idle after both lines stay high for a full bit
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) idle_cnt_q <= 3'h0;
    else if (!(scl_sync_q[1] && sda_sync_q[1])) idle_cnt_q <= 3'h0;
    else if (tick && idle_cnt_q != smbus_mem_pkg::IDLE_TICKS) idle_cnt_q <= idle_cnt_q + 3'h1;
  end

  // Byte sequencer; each bit is four quarters: data, clock up, sample, clock down
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= smbus_mem_pkg::H_IDLE;
      q_q <= 2'h0;
      bit_q <= 4'h0;
      shreg_q <= 8'h00;
      {rd_q, last_q, stop_q, held_q} <= 4'h0;
      scl_oe_n_q <= 1'b1;
      sda_oe_n_q <= 1'b1;
      ready_q <= 1'b1;
      rsp_valid_q <= 1'b0;
      rsp_data_q <= 8'h00;
      rsp_nack_q <= 1'b0;
      rsp_lost_q <= 1'b0;
    end else begin
      rsp_valid_q <= 1'b0;
      unique case (state_q)
        smbus_mem_pkg::H_IDLE: begin
          if (cmd_valid && ready_q) begin
            ready_q <= 1'b0;
            shreg_q <= cmd_wdata;
            {rd_q, last_q, stop_q} <= {cmd_read, cmd_last, cmd_stop};
            q_q <= 2'h0;
            bit_q <= 4'h0;
            state_q <= (cmd_start || !held_q) ? smbus_mem_pkg::H_START : smbus_mem_pkg::H_BIT;
          end
        end
        smbus_mem_pkg::H_START: if (tick) begin
          unique case (q_q)
            2'h0: if (held_q || idle_cnt_q == smbus_mem_pkg::IDLE_TICKS) begin
              sda_oe_n_q <= 1'b1;
              q_q <= 2'h1;
            end
            2'h1: begin
              scl_oe_n_q <= 1'b1;
              q_q <= 2'h2;
            end
            // Data falls while clock is high
            2'h2: if (scl_sync_q[1]) begin
              sda_oe_n_q <= 1'b0;
              q_q <= 2'h3;
            end
            2'h3: begin
              scl_oe_n_q <= 1'b0;
              held_q <= 1'b1;
              q_q <= 2'h0;
              state_q <= smbus_mem_pkg::H_BIT;
            end
          endcase
        end
        smbus_mem_pkg::H_BIT: if (tick) begin
          unique case (q_q)
            // Data changes only with the clock low
            2'h0: begin
              if (bit_q == smbus_mem_pkg::BITS_PER_BYTE) sda_oe_n_q <= rd_q ? last_q : 1'b1;
              else sda_oe_n_q <= rd_q ? 1'b1 : shreg_q[7];
              q_q <= 2'h1;
            end
            2'h1: begin
              scl_oe_n_q <= 1'b1;
              q_q <= 2'h2;
            end
            2'h2: if (scl_sync_q[1]) begin
              q_q <= 2'h3;
              if (bit_q != smbus_mem_pkg::BITS_PER_BYTE) begin
                shreg_q <= {shreg_q[6:0], sda_sync_q[1]};
                // Sent a one, saw a zero: release everything
                if (!rd_q && shreg_q[7] && !sda_sync_q[1]) begin
                  {scl_oe_n_q, sda_oe_n_q} <= 2'h3;
                  held_q <= 1'b0;
                  ready_q <= 1'b1;
                  rsp_valid_q <= 1'b1;
                  rsp_lost_q <= 1'b1;
                  state_q <= smbus_mem_pkg::H_IDLE;
                end
              end else begin
                rsp_nack_q <= sda_sync_q[1];
              end
            end
            2'h3: begin
              scl_oe_n_q <= 1'b0;
              q_q <= 2'h0;
              if (bit_q == smbus_mem_pkg::BITS_PER_BYTE) begin
                rsp_valid_q <= 1'b1;
                rsp_lost_q <= 1'b0;
                rsp_data_q <= shreg_q;
                if (stop_q) begin
                  state_q <= smbus_mem_pkg::H_STOP;
                end else begin
                  ready_q <= 1'b1;
                  state_q <= smbus_mem_pkg::H_IDLE;
                end
              end else begin
                bit_q <= bit_q + 4'h1;
              end
            end
          endcase
        end
        // Data rises while clock is high
        smbus_mem_pkg::H_STOP: if (tick) begin
          q_q <= q_q + 2'h1;
          unique case (q_q)
            2'h0: sda_oe_n_q <= 1'b0;
            2'h1: scl_oe_n_q <= 1'b1;
            2'h2: sda_oe_n_q <= 1'b1;
            2'h3: begin
              held_q <= 1'b0;
              ready_q <= 1'b1;
              state_q <= smbus_mem_pkg::H_IDLE;
            end
          endcase
        end
      endcase
    end
  end

  assign bus.scl_h_o = 1'b0;
  assign bus.sda_h_o = 1'b0;
  assign bus.scl_h_oe_n = scl_oe_n_q;
  assign bus.sda_h_oe_n = sda_oe_n_q;
  assign cmd_ready = ready_q;
  assign rsp_valid = rsp_valid_q;
  assign rsp_data = rsp_data_q;
  assign rsp_nack = rsp_nack_q;
  assign rsp_lost = rsp_lost_q;
endmodule // smbus_host_master

// *** sim/smbus_link_checker_assertions.sv ***
// Purpose: Concurrent checks on the open-drain link between the host and device ends.
// Assumes: Host quarter bit of 4 cycles, so each clock phase lasts 8 cycles.
// Notes: Start and stop are traced from raw wire levels; the device sees them later.
`timescale 1ns/1ns
module smbus_link_checker (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic scl_h_o,
  input wire logic scl_h_oe_n,
  input wire logic sda_h_o,
  input wire logic sda_h_oe_n,
  input wire logic scl_d_o,
  input wire logic scl_d_oe_n,
  input wire logic sda_d_o,
  input wire logic sda_d_oe_n,
  input wire logic scl,
  input wire logic sda
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  logic [1:0] hist_q;
  logic busy_q;
  logic [7:0] idle_q;
  logic [3:0] rise_q;
  logic start_w;
  logic stop_w;
  // Raw conditions, data moving while clock stays high
  assign start_w = scl & hist_q[1] & hist_q[0] & ~sda;
  assign stop_w = scl & hist_q[1] & ~hist_q[0] & sda;
  // Line history and frame ownership
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      hist_q <= 2'h3;
      busy_q <= 1'b0;
    end else begin
      hist_q <= {scl, sda};
      busy_q <= start_w | (busy_q & ~stop_w);
    end
  end
  // Idle length, and clock rises modulo nine so a byte boundary reads as zero
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      idle_q <= 8'h00;
      rise_q <= 4'h0;
    end else begin
      idle_q <= (scl & sda) ? idle_q + {7'h00, ~&idle_q} : 8'h00;
      rise_q <= start_w ? 4'h0 : (scl & ~hist_q[1]) ? ((rise_q == 4'h8) ? 4'h0 : rise_q + 4'h1)
        : rise_q;
    end
  end
  a_pull_levels: assert property (!scl_h_o && !sda_h_o && !scl_d_o && !sda_d_o)
    else $error("a driver pull level is not low");
  a_dev_no_clock: assert property (scl_d_oe_n)
    else $error("device pulls the clock line");
  a_dev_change_low: assert property ($changed(sda_d_oe_n) |-> !scl)
    else $error("device moved data while clock high");
  a_ack_stable_high: assert property ($rose(scl) && !sda_d_oe_n |-> (!sda_d_oe_n) [*8])
    else $error("device low not held through clock high");
  a_drive_in_frame: assert property (!sda_d_oe_n |-> busy_q)
    else $error("device drives data outside a transfer");
  a_drive_after_fall: assert property ($fell(sda_d_oe_n) |-> !scl && $past(scl, 10))
    else $error("device drive not just after a clock fall");
  a_start_idle: assert property (start_w && !busy_q |-> idle_q >= 8'h08)
    else $error("start on a bus that was not idle");
  a_ninth_clock: assert property (stop_w || (start_w && busy_q) |-> rise_q == 4'h1)
    else $error("transfer ended off a nine clock byte boundary");
endmodule // smbus_link_checker

// *** sim/tb_smbus_slave_memory_port.sv ***
// Purpose: Self-checking bench joining host and device ends over the two-wire link.
// Assumes: Host quarter bit shortened to 4 cycles; memory answers the cycle after mem_rd.
// Notes: Drivers note expected responses and writes; the monitor pops and compares.
`timescale 1ns/1ns
module tb_smbus_slave_memory_port;
  localparam logic [6:0] DEV_ADDR = 7'h5A; // arbitrary
  logic sys_clk = 1'b0, rstn = 1'b0, cmd_valid = 1'b0, ee_busy = 1'b0;
  logic cmd_start = 1'b0, cmd_stop = 1'b0, cmd_read = 1'b0, cmd_last = 1'b0;
  logic [7:0] cmd_wdata = 8'h00, mem_rdata = 8'h00, rsp_data, mem_wdata, d0, d1;
  logic cmd_ready, rsp_valid, rsp_nack, rsp_lost, mem_wr, mem_rd, ee_sel, ram_sel, test_sel;
  logic bus_active;
  logic [1:0] mem_bank;
  logic [9:0] mem_addr, loc;
  logic [9:0] rq[$];
  logic [22:0] wq[$];
  logic [7:0] mem [0:4095];
  int err_total = 0, checks = 0, cyc = 0, seed = 93728;
  smbus_if bus_if();
  smbus_slave_mem #(.SLAVE_ADDR(DEV_ADDR)) u_smbus_slave_mem (.sys_clk(sys_clk), .rstn(rstn),
    .bus(bus_if.dev), .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_bank(mem_bank),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .ee_sel(ee_sel), .ram_sel(ram_sel),
    .test_sel(test_sel), .mem_rdata(mem_rdata), .ee_busy(ee_busy), .bus_active(bus_active));
  smbus_host_master #(.QUARTER_CYC(4)) u_smbus_host_master (.sys_clk(sys_clk), .rstn(rstn),
    .bus(bus_if.host), .cmd_valid(cmd_valid), .cmd_start(cmd_start), .cmd_stop(cmd_stop),
    .cmd_read(cmd_read), .cmd_last(cmd_last), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_nack(rsp_nack), .rsp_lost(rsp_lost));
  smbus_link_checker u_smbus_link_checker (.sys_clk(sys_clk), .rstn(rstn),
    .scl_h_o(bus_if.scl_h_o), .scl_h_oe_n(bus_if.scl_h_oe_n), .sda_h_o(bus_if.sda_h_o),
    .sda_h_oe_n(bus_if.sda_h_oe_n), .scl_d_o(bus_if.scl_d_o), .scl_d_oe_n(bus_if.scl_d_oe_n),
    .sda_d_o(bus_if.sda_d_o), .sda_d_oe_n(bus_if.sda_d_oe_n), .scl(bus_if.scl), .sda(bus_if.sda));
  always #10 sys_clk = ~sys_clk;
  task automatic cmp(input string what, input logic [22:0] exp, input logic [22:0] got);
    checks = checks + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // One byte command; f is {start, stop, read, last}, e the expected {lost, nack, byte}
  task automatic xfer(input logic [3:0] f, input logic [7:0] d, input logic [9:0] e);
    rq.push_back(e);
    @(posedge sys_clk);
    {cmd_start, cmd_stop, cmd_read, cmd_last} <= f;
    cmd_wdata <= d;
    cmd_valid <= 1'b1;
    do @(posedge sys_clk); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
  endtask
  // Pointer set: write address, bank byte, low location byte, no stop
  task automatic point(input logic [1:0] b, input logic [9:0] l);
    xfer(4'h8, {DEV_ADDR, 1'b0}, {2'h0, DEV_ADDR, 1'b0});
    xfer(4'h0, {b, 4'h0, l[9:8]}, {2'h0, b, 4'h0, l[9:8]});
    xfer(4'h0, l[7:0], {2'h0, l[7:0]});
  endtask
  // Memory side; a read answers only on request
  always @(posedge sys_clk) begin
    if (mem_wr) mem[{mem_bank, mem_addr}] <= mem_wdata;
    if (mem_rd) mem_rdata <= mem[{mem_bank, mem_addr}];
  end
  // Monitor; the ceiling is about twice the expected run of roughly 9000 cycles
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (rsp_valid) cmp("response", rq.size() ? 23'(rq.pop_front()) : 'x,
      23'({rsp_lost, rsp_nack, rsp_data}));
    if (mem_wr) cmp("write", wq.size() ? wq.pop_front() : 'x,
      {mem_bank, mem_addr, mem_wdata, test_sel, ram_sel, ee_sel});
    if (mem_rd) cmp("read bank", 23'h1, 23'(mem_bank != smbus_mem_pkg::BANK_RSVD));
    if (mem_wr || mem_rd) cmp("active", 23'h1, 23'(bus_active));
    if (cyc == 20000) begin
      err_total = err_total + 1;
      finish_test();
    end
  end
  initial begin
    repeat (20) @(posedge sys_clk);
    rstn <= 1'b1;
    // Each bank: two bytes written then read back after a repeated start; the reserved bank reads FF
    for (int b = 0; b < 4; b++) begin
      loc = (b == 1) ? 10'h3FF : 10'($random(seed));
      d0 = 8'($random(seed));
      d1 = 8'($random(seed));
      if (b != 3) begin
        wq.push_back({2'(b), loc, d0, 3'(1 << b)});
        wq.push_back({2'(b), loc + 10'h001, d1, 3'(1 << b)}); // Location wraps in 10 bits
      end
      point(2'(b), loc);
      xfer(4'h0, d0, {2'h0, d0});
      xfer(4'h4, d1, {2'h0, d1});
      point(2'(b), loc);
      xfer(4'h8, {DEV_ADDR, 1'b1}, {2'h0, DEV_ADDR, 1'b1});
      xfer(4'h2, 8'hFF, {2'h0, (b == 3) ? 8'hFF : d0});
      xfer(4'h7, 8'hFF, {2'h1, (b == 3) ? 8'hFF : d1});
      $display("bank %0d test done", b);
    end
    xfer(4'hC, {DEV_ADDR ^ 7'h01, 1'b0}, {2'h1, DEV_ADDR ^ 7'h01, 1'b0});
    $display("foreign address test done");
    // Busy EEPROM refuses writes and reads, RAM still served
    ee_busy <= 1'b1;
    point(2'h0, 10'h010);
    xfer(4'h4, d0, {2'h1, d0});
    xfer(4'hC, {DEV_ADDR, 1'b1}, {2'h1, DEV_ADDR, 1'b1});
    wq.push_back({2'h1, 10'h005, d1, 3'h2});
    point(2'h1, 10'h005);
    xfer(4'h4, d1, {2'h0, d1});
    while (rq.size() != 0 || cmd_ready !== 1'b1) @(posedge sys_clk);
    ee_busy <= 1'b0;
    repeat (4) @(posedge sys_clk);
    cmp("writes left", 23'(wq.size()), 23'h0);
    cmp("idle", 23'h0, 23'(bus_active));
    $display("busy test done");
    finish_test();
  end
endmodule // tb_smbus_slave_memory_port
